/* File: rtl/timer01_map.svh */
`ifndef TIMER01_MAP_SVH
`define TIMER01_MAP_SVH

// Register byte addresses on the APB
`define TMR_ADDR_CONTROL 8'h00
`define TMR_ADDR_MODE 8'h04
`define TMR_ADDR_CLOCK 8'h08
`define TMR_ADDR_T0_LOW 8'h0c
`define TMR_ADDR_T0_HIGH 8'h10
`define TMR_ADDR_T1_LOW 8'h14
`define TMR_ADDR_T1_HIGH 8'h18
`define TMR_ADDR_IRQ_CFG 8'h1c

// Control register fields
`define TMR_CTL_TF1 7
`define TMR_CTL_TR1 6
`define TMR_CTL_TF0 5
`define TMR_CTL_TR0 4

// Mode register fields
`define TMR_MOD_TIMER1_GATE_ENABLE 7
`define TMR_MOD_CS1 6
`define TMR_MOD_M1_HI 5
`define TMR_MOD_M1_LO 4
`define TMR_MOD_TIMER0_GATE_ENABLE 3
`define TMR_MOD_CS0 2
`define TMR_MOD_M0_HI 1
`define TMR_MOD_M0_LO 0

// Clock control fields
`define TMR_CLK_T1SYS 3
`define TMR_CLK_T0SYS 2
`define TMR_CLK_SCA_HI 1
`define TMR_CLK_SCA_LO 0

// Interrupt configuration fields
`define TMR_CFG_POL0 0
`define TMR_CFG_POL1 1
`define TMR_CFG_ET0 2
`define TMR_CFG_ET1 3

// Prescaler terminal counts
`define TMR_DIV12_LAST 6'd11
`define TMR_DIV4_LAST 6'd3
`define TMR_DIV48_LAST 6'd47
`define TMR_EXT8_LAST 6'd7

// Count constants and reset values
`define TMR_BYTE_ONES 8'hff
`define TMR_CNT13_ONES 13'h1fff
`define TMR_CNT16_ONES 16'hffff
`define TMR_BYTE_RESET 8'h00
`define TMR_WORD_ZERO 32'h0000_0000

`endif

/* File: rtl/timer01_pkg.sv */
package timer01_pkg;

  // Operating modes of the two-bit mode fields
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_SPLIT = 2'b11
  } timer_mode_type;

  // Prescaler source choices
  typedef enum logic [1:0] {
    SCALE_DIV12 = 2'b00,
    SCALE_DIV4 = 2'b01,
    SCALE_DIV48 = 2'b10,
    SCALE_EXT8 = 2'b11
  } prescale_type;

endpackage

/* File: rtl/timer01_input_sync.sv */
// Two-flop synchroniser with a third sample for edge detection
module timer01_input_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw pin
  input wire logic din,
  // Synchronised level and edges
  output logic level,
  output logic fall,
  output logic rise
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // First flop only feeds the second to contain metastability
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // [R20] two-sample edges
  assign level = sync_reg;
  assign fall = prev_reg & ~sync_reg;
  assign rise = ~prev_reg & sync_reg;

endmodule

/* File: rtl/timer01_counter_modes.sv */
// Overview of operation
// [R1] Each timer holds a 16-bit count as separate low and high bytes.
// [R2] 13-bit mode: high byte eight MSBs, low byte bits 4..0 LSBs.
// [R3] 13-bit wrap sets overflow flag; enabled flag requests an interrupt.
// [R4] Counter select one: count falling edges on the count pin.
// [R5] Counter select zero: system clock if selected, else prescaled clock.
// [R6] Count only while run is set and, if gated, gate input active.
// [R7] Setting run never clears or presets the count bytes.
// [R8] 16-bit mode is 13-bit mode using all sixteen bits.
// [R9] Reload mode: low byte counts, reloads from high byte on overflow.
// [R10] Software loads the low byte before enabling reload mode.
// [R11] Split mode: timer 0 low byte uses timer 0 controls and flag.
// [R12] Split mode: timer 0 high byte clock only, timer 1 run, flag.
// [R13] Timer 0 split: timer 1 no pin counting, no flag, overflow out.
// [R14] Timer 1 halts in mode 3; runs in modes 0-2 when timer 0 split.
// [R15] Timer 1 implements modes 0-2 like timer 0, configured independently.
// [R16] Mode field 00 selects the 13-bit counter/timer.
// [R17] Prescale: /12, /4, /48 of system clock, external clock /8.
// [R18] Overflow flags cleared by software or by interrupt vectoring.
// [R19] Mode 01 16-bit, 10 reload, 11 split; timer 1 stopped.
// [R20] Count and gate pins synchronised; falling edge from two samples.
//
// The address map and the APB register port are this design's own decisions.
`include "timer01_map.svh"

module timer01_counter_modes (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // External count, gate and prescale clock pins
  input wire logic TIMER0_COUNT_PIN,
  input wire logic TIMER1_COUNT_PIN,
  input wire logic TIMER0_GATE_ENABLE_INPUT,
  input wire logic TIMER1_GATE_ENABLE_INPUT,
  input wire logic PRESCALE_EXT_CLOCK,
  // Interrupt vectoring acknowledges
  input wire logic TIMER0_VECTOR_ACK,
  input wire logic TIMER1_VECTOR_ACK,
  // Interrupt requests and timer 1 overflow strobe
  output logic TIMER0_IRQ,
  output logic TIMER1_IRQ,
  output logic TIMER1_OVERFLOW_PULSE
);

  // Count step for modes 0..2, returns {overflow, high, low}
  function automatic logic [16:0] count_step(
    input timer01_pkg::timer_mode_type mode,
    input logic [7:0] low,
    input logic [7:0] high
  );
    logic [12:0] c13;
    logic [15:0] c16;
    logic [16:0] res;
    c13 = {high, low[4:0]};
    c16 = {high, low};
    res = {1'b0, high, low};
    unique case (mode)
      // [R2] 13-bit count, upper low-byte bits left alone
      timer01_pkg::MODE_13BIT: begin
        c13 = c13 + 13'd1;
        // [R3] 13-bit wrap flag
        res = {({high, low[4:0]} == `TMR_CNT13_ONES), c13[12:5],
               low[7:5], c13[4:0]};
      end
      // [R8] full 16-bit count
      timer01_pkg::MODE_16BIT: begin
        c16 = c16 + 16'd1;
        res = {({high, low} == `TMR_CNT16_ONES), c16};
      end
      // [R9] reload low from high on wrap
      timer01_pkg::MODE_RELOAD8: begin
        if (low == `TMR_BYTE_ONES) begin
          res = {1'b1, high, high};
        end else begin
          res = {1'b0, high, low + 8'd1};
        end
      end
      timer01_pkg::MODE_SPLIT: begin
        res = {1'b0, high, low};
      end
    endcase
    return res;
  endfunction

  // Software state
  logic tr0_reg, tr1_reg, tf0_reg, tf1_reg;
  logic tf0_next, tf1_next;
  logic [7:0] mode_reg;
  logic [3:0] clk_ctl_reg;
  logic [3:0] irq_cfg_reg;
  // [R1] count bytes
  logic [7:0] t0_low_reg, t0_high_reg, t1_low_reg, t1_high_reg;
  logic [7:0] t0_low_next, t0_high_next, t1_low_next, t1_high_next;
  // Prescaler
  logic [5:0] presc_cnt_reg;
  logic [5:0] presc_cnt_next;
  logic presc_tick;
  // Bus, interrupt request and overflow strobe outputs
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  logic irq0_reg, irq1_reg, t1_ovf_pulse_reg;

  // Synchronised pins
  logic t0_pin_fall, t1_pin_fall, ext_rise;
  logic timer0_gate_enable_level, timer1_gate_enable_level;

  timer01_input_sync sync_t0 (.clk(MCLK), .rst(RST),
    .din(TIMER0_COUNT_PIN), .level(), .fall(t0_pin_fall), .rise());
  timer01_input_sync sync_t1 (.clk(MCLK), .rst(RST),
    .din(TIMER1_COUNT_PIN), .level(), .fall(t1_pin_fall), .rise());
  timer01_input_sync sync_g0 (.clk(MCLK), .rst(RST),
    .din(TIMER0_GATE_ENABLE_INPUT), .level(timer0_gate_enable_level), .fall(), .rise());
  timer01_input_sync sync_g1 (.clk(MCLK), .rst(RST),
    .din(TIMER1_GATE_ENABLE_INPUT), .level(timer1_gate_enable_level), .fall(), .rise());
  timer01_input_sync sync_ext (.clk(MCLK), .rst(RST),
    .din(PRESCALE_EXT_CLOCK), .level(), .fall(), .rise(ext_rise));

  // Field decode
  timer01_pkg::timer_mode_type mode0, mode1;
  timer01_pkg::prescale_type scale;
  wire timer0_gate_enable_en = mode_reg[`TMR_MOD_TIMER0_GATE_ENABLE];
  wire timer1_gate_enable_en = mode_reg[`TMR_MOD_TIMER1_GATE_ENABLE];
  wire cs0 = mode_reg[`TMR_MOD_CS0];
  wire cs1 = mode_reg[`TMR_MOD_CS1];
  wire t0_sys = clk_ctl_reg[`TMR_CLK_T0SYS];
  wire t1_sys = clk_ctl_reg[`TMR_CLK_T1SYS];
  wire pol0 = irq_cfg_reg[`TMR_CFG_POL0];
  wire pol1 = irq_cfg_reg[`TMR_CFG_POL1];
  wire et0 = irq_cfg_reg[`TMR_CFG_ET0];
  wire et1 = irq_cfg_reg[`TMR_CFG_ET1];
  // [R16] [R19] mode field decode
  assign mode0 = timer01_pkg::timer_mode_type'(
    mode_reg[`TMR_MOD_M0_HI:`TMR_MOD_M0_LO]);
  assign mode1 = timer01_pkg::timer_mode_type'(
    mode_reg[`TMR_MOD_M1_HI:`TMR_MOD_M1_LO]);
  assign scale = timer01_pkg::prescale_type'(
    clk_ctl_reg[`TMR_CLK_SCA_HI:`TMR_CLK_SCA_LO]);
  wire t0_split = (mode0 == timer01_pkg::MODE_SPLIT);
  wire t1_stopped = (mode1 == timer01_pkg::MODE_SPLIT);

  // APB decode; writes land on the completing access edge
  wire bus_done = PSEL & PENABLE & pready_reg;
  wire bus_wr = bus_done & PWRITE;
  wire [7:0] wbyte = PWDATA[7:0];
  wire wr_ctl = bus_wr & (PADDR == `TMR_ADDR_CONTROL);
  wire wr_mode = bus_wr & (PADDR == `TMR_ADDR_MODE);
  wire wr_clk = bus_wr & (PADDR == `TMR_ADDR_CLOCK);
  wire wr_t0l = bus_wr & (PADDR == `TMR_ADDR_T0_LOW);
  wire wr_t0h = bus_wr & (PADDR == `TMR_ADDR_T0_HIGH);
  wire wr_t1l = bus_wr & (PADDR == `TMR_ADDR_T1_LOW);
  wire wr_t1h = bus_wr & (PADDR == `TMR_ADDR_T1_HIGH);
  wire wr_cfg = bus_wr & (PADDR == `TMR_ADDR_IRQ_CFG);
  wire addr_hit = (PADDR == `TMR_ADDR_CONTROL) |
    (PADDR == `TMR_ADDR_MODE) | (PADDR == `TMR_ADDR_CLOCK) |
    (PADDR == `TMR_ADDR_T0_LOW) | (PADDR == `TMR_ADDR_T0_HIGH) |
    (PADDR == `TMR_ADDR_T1_LOW) | (PADDR == `TMR_ADDR_T1_HIGH) |
    (PADDR == `TMR_ADDR_IRQ_CFG);

  // Read mux; unused upper bits read as zero
  logic [7:0] rd_byte;
  assign rd_byte =
    (PADDR == `TMR_ADDR_CONTROL) ?
      {tf1_reg, tr1_reg, tf0_reg, tr0_reg, 4'h0} :
    (PADDR == `TMR_ADDR_MODE) ? mode_reg :
    (PADDR == `TMR_ADDR_CLOCK) ? {4'h0, clk_ctl_reg} :
    (PADDR == `TMR_ADDR_T0_LOW) ? t0_low_reg :
    (PADDR == `TMR_ADDR_T0_HIGH) ? t0_high_reg :
    (PADDR == `TMR_ADDR_T1_LOW) ? t1_low_reg :
    (PADDR == `TMR_ADDR_T1_HIGH) ? t1_high_reg :
    (PADDR == `TMR_ADDR_IRQ_CFG) ? {4'h0, irq_cfg_reg} : 8'h00;

  // [R17] prescaler terminal count per scale setting
  logic [5:0] presc_last;
  assign presc_last =
    (scale == timer01_pkg::SCALE_DIV12) ? `TMR_DIV12_LAST :
    (scale == timer01_pkg::SCALE_DIV4) ? `TMR_DIV4_LAST :
    (scale == timer01_pkg::SCALE_DIV48) ? `TMR_DIV48_LAST :
    `TMR_EXT8_LAST;
  wire ext_scale = (scale == timer01_pkg::SCALE_EXT8);
  // External mode advances only on synchronised rising edges
  wire presc_step = ext_scale ? ext_rise : 1'b1;
  assign presc_tick = presc_step & (presc_cnt_reg >= presc_last);
  assign presc_cnt_next = presc_tick ? 6'd0 :
    (presc_step ? presc_cnt_reg + 6'd1 : presc_cnt_reg);

  // [R5] timer clock source per timer
  wire clk_src0 = t0_sys | presc_tick;
  wire clk_src1 = t1_sys | presc_tick;
  // [R6] run and gate qualification
  wire timer0_gate_enable_ok = ~timer0_gate_enable_en | (timer0_gate_enable_level == pol0);
  wire timer1_gate_enable_ok = ~timer1_gate_enable_en | (timer1_gate_enable_level == pol1);
  // [R4] [R11] pin edges or clock for timer 0 and its split low byte
  wire tick0 = tr0_reg & timer0_gate_enable_ok & (cs0 ? t0_pin_fall : clk_src0);
  // [R12] split high byte: clock only, started by timer 1 run
  wire tick_split_hi = t0_split & tr1_reg & clk_src1;
  // [R13] [R14] timer 1 run and source while timer 0 is split
  wire t1_enable = ~t1_stopped &
    (t0_split ? 1'b1 : (tr1_reg & timer1_gate_enable_ok));
  wire tick1 = t1_enable &
    ((cs1 & ~t0_split) ? t1_pin_fall : clk_src1);

  logic [16:0] step0, step1;
  logic t0_ovf, t1_ovf, split_hi_ovf;
  // [R15] same step function for both timers
  assign step0 = count_step(mode0, t0_low_reg, t0_high_reg);
  assign step1 = count_step(mode1, t1_low_reg, t1_high_reg);

  // Timer 0 next state; software byte writes win over counting
  always_comb begin
    t0_low_next = t0_low_reg;
    t0_high_next = t0_high_reg;
    t0_ovf = 1'b0;
    split_hi_ovf = 1'b0;
    if (t0_split) begin
      // [R11] low byte as an independent 8-bit counter
      if (tick0) begin
        t0_low_next = t0_low_reg + 8'd1;
        t0_ovf = (t0_low_reg == `TMR_BYTE_ONES);
      end
      // [R12] high byte overflow feeds timer 1 flag
      if (tick_split_hi) begin
        t0_high_next = t0_high_reg + 8'd1;
        split_hi_ovf = (t0_high_reg == `TMR_BYTE_ONES);
      end
    end else if (tick0) begin
      {t0_ovf, t0_high_next, t0_low_next} = step0;
    end
    // [R1] [R7] loads come from software, or from the high byte in reload mode
    if (wr_t0l) begin
      t0_low_next = wbyte;
    end
    if (wr_t0h) begin
      t0_high_next = wbyte;
    end
  end

  // Timer 1 next state
  always_comb begin
    t1_low_next = t1_low_reg;
    t1_high_next = t1_high_reg;
    t1_ovf = 1'b0;
    if (tick1) begin
      {t1_ovf, t1_high_next, t1_low_next} = step1;
    end
    if (wr_t1l) begin
      t1_low_next = wbyte;
    end
    if (wr_t1h) begin
      t1_high_next = wbyte;
    end
  end

  // [R18] flags: hardware set beats software or vector clear
  wire set_tf0 = t0_ovf;
  // [R13] timer 1 flag comes from split high byte only while timer 0 is split
  wire set_tf1 = t0_split ? split_hi_ovf : t1_ovf;
  assign tf0_next = set_tf0 | (wr_ctl ? wbyte[`TMR_CTL_TF0] :
    (tf0_reg & ~TIMER0_VECTOR_ACK));
  assign tf1_next = set_tf1 | (wr_ctl ? wbyte[`TMR_CTL_TF1] :
    (tf1_reg & ~TIMER1_VECTOR_ACK));

  // Control and configuration registers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tr0_reg <= 1'b0;
      tr1_reg <= 1'b0;
      mode_reg <= `TMR_BYTE_RESET;
      clk_ctl_reg <= 4'h0;
      irq_cfg_reg <= 4'h0;
    end else begin
      // [R7] run bits touch no count byte
      if (wr_ctl) begin
        tr0_reg <= wbyte[`TMR_CTL_TR0];
        tr1_reg <= wbyte[`TMR_CTL_TR1];
      end
      if (wr_mode) begin
        mode_reg <= wbyte;
      end
      if (wr_clk) begin
        clk_ctl_reg <= wbyte[3:0];
      end
      if (wr_cfg) begin
        irq_cfg_reg <= wbyte[3:0];
      end
    end
  end

  // Count bytes, flags and prescaler
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      t0_low_reg <= `TMR_BYTE_RESET;
      t0_high_reg <= `TMR_BYTE_RESET;
      t1_low_reg <= `TMR_BYTE_RESET;
      t1_high_reg <= `TMR_BYTE_RESET;
      tf0_reg <= 1'b0;
      tf1_reg <= 1'b0;
      presc_cnt_reg <= 6'd0;
    end else begin
      t0_low_reg <= t0_low_next;
      t0_high_reg <= t0_high_next;
      t1_low_reg <= t1_low_next;
      t1_high_reg <= t1_high_next;
      tf0_reg <= tf0_next;
      tf1_reg <= tf1_next;
      presc_cnt_reg <= presc_cnt_next;
    end
  end

  // Registered outputs; a request drops on the same edge as its flag clears
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      irq0_reg <= 1'b0;
      irq1_reg <= 1'b0;
      t1_ovf_pulse_reg <= 1'b0;
    end else begin
      // [R3] request follows flag and enable
      irq0_reg <= tf0_next & et0;
      irq1_reg <= tf1_next & et1;
      // [R13] overflow strobe for baud and converter start
      t1_ovf_pulse_reg <= t1_ovf;
    end
  end

  // APB answer: one wait state, ready lasts one cycle
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= `TMR_WORD_ZERO;
    end else begin
      pready_reg <= PSEL & PENABLE & ~pready_reg;
      pslverr_reg <= PSEL & PENABLE & ~pready_reg & ~addr_hit;
      if (PSEL & PENABLE & ~pready_reg & ~PWRITE) begin
        prdata_reg <= {24'h000000, rd_byte};
      end
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign TIMER0_IRQ = irq0_reg;
  assign TIMER1_IRQ = irq1_reg;
  assign TIMER1_OVERFLOW_PULSE = t1_ovf_pulse_reg;

endmodule

/* File: test/timer01_pin_model.sv */
module timer01_pin_model (
  // System clock
  input wire logic clk,
  // Pins driven into the timer block
  output logic cnt0,
  output logic cnt1,
  output logic timer0_gate_enable,
  output logic timer1_gate_enable,
  output logic ext_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  // Count pins idle high, so the first drop is a real falling edge
  initial begin
    cnt0 = 1'b1;
    cnt1 = 1'b1;
    timer0_gate_enable = 1'b0;
    timer1_gate_enable = 1'b0;
    ext_clk = 1'b0;
  end
  task automatic pulse(input bit sel, input int n, input int hold);
    repeat (n) begin
      @(posedge clk);
      if (sel) cnt1 <= 1'b0;
      else cnt0 <= 1'b0;
      repeat (hold) @(posedge clk);
      if (sel) cnt1 <= 1'b1;
      else cnt0 <= 1'b1;
      repeat (hold) @(posedge clk);
    end
  endtask
  task automatic ext(input int n);
    repeat (n) begin
      @(posedge clk);
      ext_clk <= 1'b1;
      repeat (3) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic gate(input bit sel, input bit lvl);
    @(posedge clk);
    if (sel) timer1_gate_enable <= lvl;
    else timer0_gate_enable <= lvl;
    repeat (4) @(posedge clk);
  endtask
endmodule

/* File: test/timer01_monitor.sv */
module timer01_monitor (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Acknowledges and requests
  input wire logic TIMER0_VECTOR_ACK,
  input wire logic TIMER1_VECTOR_ACK,
  input wire logic TIMER0_IRQ,
  input wire logic TIMER1_IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // Of bus transfers, only a finished write may clear a flag or an enable
  wire logic wr_done = PSEL && PENABLE && PREADY && PWRITE;

  property p_one_wait;
    PSEL && !PENABLE ##1 PSEL && PENABLE |-> !PREADY ##1 PREADY;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("ready not after one wait state");
  property p_ready_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  property p_ready_access;
    PREADY |-> PSEL && PENABLE;
  endproperty
  a_ready_access: assert property (p_ready_access)
    else $error("ready outside access");
  property p_unmapped;
    PREADY && PADDR[1:0] == 2'b00 |-> PSLVERR == (PADDR > 8'h1c);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("error flag wrong for address");
  property p_err_zero;
    PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("refused read returned data");
  property p_byte_wide;
    PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0;
  endproperty
  a_byte_wide: assert property (p_byte_wide)
    else $error("read data above one byte");
  property p_rdata_hold;
    !$stable(PRDATA) |-> PREADY && !PWRITE;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  // Ack or control write drops a request one edge on; clearing the
  // enable goes through the config register, so two edges on
  property p_irq0_drop;
    $fell(TIMER0_IRQ) |->
      $past(TIMER0_VECTOR_ACK) || $past(wr_done) || $past(wr_done, 2);
  endproperty
  a_irq0_drop: assert property (p_irq0_drop)
    else $error("timer 0 request dropped unprompted");
  property p_irq1_drop;
    $fell(TIMER1_IRQ) |->
      $past(TIMER1_VECTOR_ACK) || $past(wr_done) || $past(wr_done, 2);
  endproperty
  a_irq1_drop: assert property (p_irq1_drop)
    else $error("timer 1 request dropped unprompted");
  // Main scenarios reached
  c_err: cover property (PREADY && PSLVERR);
  c_irq0: cover property ($rose(TIMER0_IRQ));
  c_irq1: cover property ($rose(TIMER1_IRQ));
endmodule

bind timer01_counter_modes timer01_monitor mon_u (.MCLK(MCLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TIMER0_VECTOR_ACK(TIMER0_VECTOR_ACK), .TIMER0_IRQ(TIMER0_IRQ),
  .TIMER1_VECTOR_ACK(TIMER1_VECTOR_ACK), .TIMER1_IRQ(TIMER1_IRQ));

/* File: test/timer01_counter_modes_tb_top.sv */
module timer01_counter_modes_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, psel, penable, pwrite, ack0, ack1;
  logic pready, pslverr, rerr, irq0, irq1, ovf1;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  wire logic cnt0, cnt1, g0, g1, xclk;
  int bad_count, num_checks, cyc;
  int divs[5] = '{12, 4, 48, 8, 1};

  // Clock at 100 MHz
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  timer01_counter_modes dut_u (
    .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .TIMER0_COUNT_PIN(cnt0),
    .TIMER1_COUNT_PIN(cnt1), .TIMER0_GATE_ENABLE_INPUT(g0), .TIMER1_GATE_ENABLE_INPUT(g1),
    .PRESCALE_EXT_CLOCK(xclk), .TIMER0_VECTOR_ACK(ack0),
    .TIMER1_VECTOR_ACK(ack1), .TIMER0_IRQ(irq0), .TIMER1_IRQ(irq1),
    .TIMER1_OVERFLOW_PULSE(ovf1));
  timer01_pin_model pins (.clk(mclk), .cnt0(cnt0), .cnt1(cnt1),
    .timer0_gate_enable(g0), .timer1_gate_enable(g1), .ext_clk(xclk));

  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Cycle count; the ceiling cuts a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, e, input logic [7:0] m = 8'hff);
    apb(1'b0, a, 32'h0);
    chk({1'b0, rdata & {24'hff_ffff, m}}, {25'h0, e});
  endtask

  // Stop, pick mode, load both bytes while halted, then run
  task automatic setup(input logic [7:0] m, b, lo, hi, ctl);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, {24'h0, m});
    apb(1'b1, b, {24'h0, lo});
    apb(1'b1, b + 8'h04, {24'h0, hi});
    apb(1'b1, 8'h00, {24'h0, ctl});
  endtask

  task automatic ack(input bit s);
    @(posedge mclk);
    if (s) ack1 <= 1'b1;
    else ack0 <= 1'b1;
    @(posedge mclk);
    {ack0, ack1} <= 2'b00;
    repeat (3) @(posedge mclk);
  endtask

  initial begin
    int t0;
    int n;
    bit near;
    {rst, psel, penable, pwrite, ack0, ack1} = 6'b100000;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rc(8'(4 * i), 8'h00);
    apb(1'b0, 8'h20, 32'h0);
    chk({rerr, rdata}, 33'h1_0000_0000);
    for (int i = 3; i < 7; i++) apb(1'b1, 8'(4 * i), 32'(8'h11 * i));
    for (int i = 3; i < 7; i++) rc(8'(4 * i), 8'(8'h11 * i));
    // Pin edges in 16-bit mode, then the request and its acknowledge
    apb(1'b1, 8'h1c, 32'h04);
    setup(8'h05, 8'h0c, 8'hfe, 8'hff, 8'h10);
    rc(8'h0c, 8'hfe);
    pins.pulse(1'b0, 3, 2);
    rc(8'h0c, 8'h01);
    rc(8'h10, 8'h00);
    rc(8'h00, 8'h30);
    chk({32'h0, irq0}, 33'h1);
    ack(1'b0);
    chk({32'h0, irq0}, 33'h0);
    rc(8'h00, 8'h10);
    // 13-bit wrap, then a software clear
    setup(8'h04, 8'h0c, 8'hfe, 8'hff, 8'h10);
    pins.pulse(1'b0, 2, 3);
    rc(8'h0c, 8'h00, 8'h1f);
    rc(8'h10, 8'h00);
    rc(8'h00, 8'h30);
    apb(1'b1, 8'h00, 32'h10);
    rc(8'h00, 8'h10);
    // Auto-reload keeps the high byte
    setup(8'h06, 8'h0c, 8'hfe, 8'h80, 8'h10);
    pins.pulse(1'b0, 3, 2);
    rc(8'h0c, 8'h81);
    rc(8'h10, 8'h80);
    rc(8'h00, 8'h30);
    // Gate with both polarities
    apb(1'b1, 8'h1c, 32'h01);
    setup(8'h0d, 8'h0c, 8'h00, 8'h00, 8'h10);
    pins.pulse(1'b0, 2, 2);
    rc(8'h0c, 8'h00);
    pins.gate(1'b0, 1'b1);
    pins.pulse(1'b0, 2, 2);
    rc(8'h0c, 8'h02);
    apb(1'b1, 8'h1c, 32'h00);
    pins.gate(1'b0, 1'b0);
    pins.pulse(1'b0, 1, 2);
    rc(8'h0c, 8'h03);
    // Clock sources; the prescaler phase allows one count either way
    for (int i = 0; i < 5; i++) begin
      setup(8'h01, 8'h0c, 8'h00, 8'h00, 8'h00);
      apb(1'b1, 8'h08, 32'(i == 4 ? 4 : i));
      apb(1'b1, 8'h00, 32'h10);
      t0 = cyc;
      if (i == 3) pins.ext(16);
      else repeat (150) @(posedge mclk);
      apb(1'b1, 8'h00, 32'h0);
      n = i == 3 ? 2 : (cyc - t0) / divs[i];
      apb(1'b0, 8'h0c, 32'h0);
      near = rdata >= 32'(n - 1) && rdata <= 32'(n + 1);
      chk({32'h0, near}, 33'h1);
    end
    // Split timer 0; timer 1 halted in mode 3
    apb(1'b1, 8'h1c, 32'h08);
    apb(1'b1, 8'h08, 32'h08);
    setup(8'h77, 8'h0c, 8'h00, 8'hf0, 8'h10);
    pins.pulse(1'b1, 2, 2);
    pins.pulse(1'b0, 2, 2);
    rc(8'h0c, 8'h02);
    rc(8'h10, 8'hf0);
    apb(1'b1, 8'h00, 32'h50);
    repeat (20) @(posedge mclk);
    rc(8'h00, 8'hd0);
    chk({32'h0, irq1}, 33'h1);
    rc(8'h14, 8'h55);
    // Halt the split high byte; timer 1 overflows then pulse out but set no flag
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b1, 8'h04, 32'h67);
    n = 0;
    repeat (300) @(posedge mclk) if (ovf1 === 1'b1) n++;
    chk(33'(n > 0), 33'h1);
    rc(8'h00, 8'h10);
    // Timer 1 alone in 16-bit mode, gated active high
    apb(1'b1, 8'h1c, 32'h0a);
    setup(8'hd0, 8'h14, 8'hfe, 8'hff, 8'h40);
    pins.pulse(1'b1, 1, 2);
    rc(8'h14, 8'hfe);
    pins.gate(1'b1, 1'b1);
    pins.pulse(1'b1, 3, 2);
    rc(8'h14, 8'h01);
    rc(8'h00, 8'hc0);
    chk({32'h0, irq1}, 33'h1);
    ack(1'b1);
    chk({32'h0, irq1}, 33'h0);
    results();
  end
endmodule
